// [flc_pkg.sv]
package flc_pkg;

  // clock and figures as specified
  localparam real CLK_NS          = 8.0;
  localparam real T_PSUS_TYP_US   = 9.4;
  localparam real T_ESUS_TYP_US   = 16.0;
  localparam real T_ABORT_TYP_US  = 16.0;
  localparam real T_MRSTOP_MIN_US = 10.36;
  localparam real T_AISTOP_MAX_NS = 80.0;
  localparam real T_RCV_MIN_US    = 16.0;
  localparam int  PLUS_FOUR       = 4;
  localparam int  PLUS_SEVEN      = 7;
  localparam int  PLUS_FIFTEEN    = 15;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] PSUS_CNT =
    CNT_W'(int'($ceil(T_PSUS_TYP_US * 1000.0 / CLK_NS)) + PLUS_FOUR);
  localparam logic [CNT_W-1:0] ESUS_CNT =
    CNT_W'(int'($ceil(T_ESUS_TYP_US * 1000.0 / CLK_NS)) + PLUS_FOUR);
  localparam logic [CNT_W-1:0] ABORT_CNT =
    CNT_W'(int'($ceil(T_ABORT_TYP_US * 1000.0 / CLK_NS)) + PLUS_FOUR);
  localparam logic [CNT_W-1:0] MRSTOP_CNT =
    CNT_W'(int'($ceil(T_MRSTOP_MIN_US * 1000.0 / CLK_NS)) + PLUS_FOUR);
  localparam logic [CNT_W-1:0] AISTOP_CNT =
    CNT_W'(int'($floor(T_AISTOP_MAX_NS / CLK_NS)) + PLUS_FIFTEEN);
  localparam logic [CNT_W-1:0] RCV_CNT =
    CNT_W'(int'($ceil(T_RCV_MIN_US * 1000.0 / CLK_NS)) + PLUS_SEVEN);

  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS    = 8'h04;
  localparam logic [7:0] RDCFG_OFS   = 8'h08;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h0c;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h10;

  // control bit positions
  localparam int CTRL_W    = 9;
  localparam int C_HV      = 0;
  localparam int C_PSUS    = 1;
  localparam int C_ESUS    = 2;
  localparam int C_ERASE   = 3;
  localparam int C_AIE     = 4;
  localparam int C_INTEGRITY_CHECK_SUSPEND   = 5;
  localparam int C_INTEGRITY_BREAKPOINT_NEGATE   = 6;
  localparam int C_MARGIN  = 7;
  localparam int C_LOWPWR  = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // read configuration fields
  localparam int RWS_W   = 3;
  localparam int APS_W   = 2;
  localparam int RWS_POS = 0;
  localparam int APS_POS = 4;
  localparam logic [RWS_W-1:0] RWS_RST = 3'h0;
  localparam logic [APS_W-1:0] APS_RST = 2'h0;

  // interrupt bits
  localparam int IRQ_W        = 3;
  localparam int I_OP_DONE    = 0;
  localparam int I_CHK_DONE   = 1;
  localparam int I_RCV_DONE   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic [4:0] {
    OP_IDLE = 5'b00001,
    OP_RUN  = 5'b00010,
    OP_STOP = 5'b00100,
    OP_SUSP = 5'b01000,
    OP_END  = 5'b10000
  } flc_op_st_t;

  typedef enum logic [4:0] {
    CK_IDLE = 5'b00001,
    CK_RUN  = 5'b00010,
    CK_STOP = 5'b00100,
    CK_SUSP = 5'b01000,
    CK_END  = 5'b10000
  } flc_chk_st_t;

  function automatic logic [31:0] flc_merge(input logic [31:0] old_v,
                                            input logic [31:0] wr_v,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (wr_v & m);
  endfunction : flc_merge

endpackage : flc_pkg

// [flc_flash_seq.sv]
// Notes on behaviour
// (RL1) program suspend sets completion flag 9.4 us typ plus four clocks later
// (RL2) erase suspend sets completion flag 16 us typ plus four clocks later
// (RL3) clearing suspend with hv enable still set resumes, flag low fast
// (RL4) hv enable rising starts operation, completion flag cleared next edge
// (RL5) hv enable falling aborts, completion flag set 16 us plus four clocks
// (RL6) leaving low power needs 16 us plus seven clocks before ready
// (RL7) check enable rising or resume clears check-done at the next edge
// (RL8) integrity abort or suspend sets check-done within 80 ns plus 15 clocks
// (RL9) margin read abort or suspend sets check-done 10.36 us plus four clocks
// (RL10) software picks wait states and pipeline setting by flash clock
// (RL11) completion flags read one while nothing is in progress
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
module flc_flash_seq #(
  parameter int OP_CYCLES  = 1000,
  parameter int CHK_CYCLES = 1000
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           irq_o,
  output logic                           hv_operation_enable_o,
  output logic                           done_o,
  output logic                           integrity_check_done_o,
  output logic                           flash_ready_o,
  output logic      [flc_pkg::RWS_W-1:0] read_wait_states_o,
  output logic      [flc_pkg::APS_W-1:0] addr_pipeline_setting_o
);
  import flc_pkg::*;

  if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_op_chk
    $error("OP_CYCLES out of range");
  end
  if (CHK_CYCLES < 1 || CHK_CYCLES > 65535) begin : g_chk_chk
    $error("CHK_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] OP_LEN  = CNT_W'(OP_CYCLES);
  localparam logic [CNT_W-1:0] CHK_LEN = CNT_W'(CHK_CYCLES);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [RWS_W-1:0]  rws;
    logic [APS_W-1:0]  aps;
    flc_op_st_t        op;
    logic              op_erase;
    logic              op_abort;
    logic [CNT_W-1:0]  op_left;
    logic [CNT_W-1:0]  op_tmr;
    flc_chk_st_t       chk;
    logic              chk_abort;
    logic [CNT_W-1:0]  chk_left;
    logic [CNT_W-1:0]  chk_tmr;
    logic              rcv;
    logic [CNT_W-1:0]  rcv_tmr;
    logic              done;
    logic              cdone;
    logic              ready;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_msk;
    logic              irq;
    logic              ack;
    logic [31:0]       dat;
  } flc_state_t;

  flc_state_t q;
  flc_state_t s;

  logic              req;
  logic              wr;
  logic              rd_clr;
  logic [CTRL_W-1:0] nc;
  logic [31:0]       wv;
  logic [IRQ_W-1:0]  ev;
  logic              hv_rise;
  logic              hv_fall;
  logic              sus_req;
  logic              sus_off;

  always_comb
  begin
    s       = q;
    req     = wb_cyc_i & wb_stb_i;
    // write and read-clear act at the edge that samples ack
    wr      = req & q.ack & wb_we_i;
    rd_clr  = req & q.ack & ~wb_we_i & (wb_adr_i == IRQ_ST_OFS);
    s.ack   = req & ~q.ack;
    ev      = '0;
    nc      = q.ctrl;
    wv      = '0;
    if (wr && wb_adr_i == CTRL_OFS)
    begin
      wv = flc_merge({23'h000000, q.ctrl}, wb_dat_i, wb_sel_i);
      nc = wv[CTRL_W-1:0];
    end
    else if (wr && wb_adr_i == RDCFG_OFS)
    begin
      wv = flc_merge({26'h0000000, q.aps, 1'b0, q.rws}, wb_dat_i, wb_sel_i);
      s.rws = wv[RWS_POS +: RWS_W]; // [RL10]
      s.aps = wv[APS_POS +: APS_W]; // [RL10]
    end
    else if (wr && wb_adr_i == IRQ_MSK_OFS)
    begin
      wv = flc_merge({29'h00000000, q.irq_msk}, wb_dat_i, wb_sel_i);
      s.irq_msk = wv[IRQ_W-1:0];
    end
    s.ctrl  = nc;
    hv_rise = nc[C_HV] & ~q.ctrl[C_HV];
    hv_fall = ~nc[C_HV] & q.ctrl[C_HV];
    sus_req = q.op_erase ? (nc[C_ESUS] & ~q.ctrl[C_ESUS])
                         : (nc[C_PSUS] & ~q.ctrl[C_PSUS]);
    sus_off = q.op_erase ? ~nc[C_ESUS] : ~nc[C_PSUS];

    // program / erase sequencer
    case (q.op)
      OP_IDLE:
      begin
        s.done = 1'b1; // [RL11]
        if (hv_rise && q.ready)
        begin
          s.op       = OP_RUN;
          s.op_erase = nc[C_ERASE];
          s.op_left  = OP_LEN;
          s.done     = 1'b0; // [RL4]
        end
      end
      OP_RUN:
      begin
        s.op_left = q.op_left - 1'b1;
        if (hv_fall)
        begin
          s.op       = OP_STOP;
          s.op_abort = 1'b1;
          s.op_tmr   = ABORT_CNT - 1'b1; // [RL5]
        end
        else if (sus_req)
        begin
          s.op       = OP_STOP;
          s.op_abort = 1'b0;
          // [RL1] [RL2]
          s.op_tmr   = (q.op_erase ? ESUS_CNT : PSUS_CNT) - 1'b1;
        end
        else if (q.op_left == 1)
        begin
          s.op   = OP_END;
          s.done = 1'b1;
        end
      end
      OP_STOP:
      begin
        // latency runs to its end, later requests wait behind it
        s.op_tmr = q.op_tmr - 1'b1;
        if (q.op_tmr == 0)
        begin
          s.done = 1'b1; // [RL1] [RL2] [RL5]
          s.op   = (q.op_abort || !nc[C_HV]) ? OP_IDLE : OP_SUSP;
        end
      end
      OP_SUSP:
      begin
        if (!nc[C_HV])
          s.op = OP_IDLE;
        else if (sus_off)
        begin
          s.op   = OP_RUN;
          s.done = 1'b0; // [RL3]
        end
      end
      OP_END:
      begin
        if (!nc[C_HV])
          s.op = OP_IDLE;
      end
      default:
      begin
        s.op   = OP_IDLE;
        s.done = 1'b1;
      end
    endcase

    // margin read / array integrity sequencer
    case (q.chk)
      CK_IDLE:
      begin
        s.cdone = 1'b1; // [RL11]
        if (nc[C_AIE] && !q.ctrl[C_AIE] && q.ready)
        begin
          s.chk      = CK_RUN;
          s.chk_left = CHK_LEN;
          s.cdone    = 1'b0; // [RL7]
        end
      end
      CK_RUN:
      begin
        s.chk_left = q.chk_left - 1'b1;
        if (!nc[C_AIE] || (nc[C_INTEGRITY_CHECK_SUSPEND] && !q.ctrl[C_INTEGRITY_CHECK_SUSPEND]))
        begin
          s.chk       = CK_STOP;
          s.chk_abort = ~nc[C_AIE];
          // margin read stops far slower than integrity check
          s.chk_tmr   = (nc[C_MARGIN] ? MRSTOP_CNT : AISTOP_CNT)
                        - 1'b1; // [RL8] [RL9]
        end
        else if (q.chk_left == 1)
        begin
          s.chk   = CK_END;
          s.cdone = 1'b1;
        end
      end
      CK_STOP:
      begin
        s.chk_tmr = q.chk_tmr - 1'b1;
        if (q.chk_tmr == 0)
        begin
          s.cdone = 1'b1; // [RL8] [RL9]
          s.chk   = (q.chk_abort || !nc[C_AIE]) ? CK_IDLE : CK_SUSP;
        end
      end
      CK_SUSP:
      begin
        if (!nc[C_AIE])
          s.chk = CK_IDLE;
        else if ((!nc[C_INTEGRITY_CHECK_SUSPEND] && q.ctrl[C_INTEGRITY_CHECK_SUSPEND]) ||
                 (!nc[C_INTEGRITY_BREAKPOINT_NEGATE] && q.ctrl[C_INTEGRITY_BREAKPOINT_NEGATE]))
        begin
          s.chk   = CK_RUN;
          s.cdone = 1'b0; // [RL7]
        end
      end
      CK_END:
      begin
        if (!nc[C_AIE])
          s.chk = CK_IDLE;
      end
      default:
      begin
        s.chk   = CK_IDLE;
        s.cdone = 1'b1;
      end
    endcase

    // low power exit recovery
    if (!nc[C_LOWPWR] && q.ctrl[C_LOWPWR])
    begin
      s.rcv     = 1'b1;
      s.rcv_tmr = RCV_CNT - 1'b1; // [RL6]
    end
    else if (q.rcv)
    begin
      s.rcv_tmr = q.rcv_tmr - 1'b1;
      if (q.rcv_tmr == 0)
      begin
        s.rcv             = 1'b0; // [RL6]
        ev[I_RCV_DONE]    = 1'b1;
      end
    end
    s.ready = ~nc[C_LOWPWR] & ~s.rcv; // [RL6]

    ev[I_OP_DONE]  = s.done & ~q.done;
    ev[I_CHK_DONE] = s.cdone & ~q.cdone;
    // set wins over the read clear
    s.irq_st = (q.irq_st & ~(rd_clr ? q.dat[IRQ_W-1:0] : IRQ_RST)) | ev;
    s.irq    = |(s.irq_st & s.irq_msk);

    if (s.ack)
    begin
      if (wb_adr_i == CTRL_OFS)
        s.dat = {23'h000000, q.ctrl};
      else if (wb_adr_i == STAT_OFS)
        s.dat = {26'h0000000, q.rcv, q.ready, q.chk != CK_IDLE,
                 q.op != OP_IDLE, q.cdone, q.done};
      else if (wb_adr_i == RDCFG_OFS)
        s.dat = {26'h0000000, q.aps, 1'b0, q.rws};
      else if (wb_adr_i == IRQ_ST_OFS)
        s.dat = {29'h00000000, q.irq_st};
      else if (wb_adr_i == IRQ_MSK_OFS)
        s.dat = {29'h00000000, q.irq_msk};
      else
        s.dat = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q           <= '0;
      q.ctrl      <= CTRL_RST;
      q.rws       <= RWS_RST;
      q.aps       <= APS_RST;
      q.op        <= OP_IDLE;
      q.chk       <= CK_IDLE;
      q.done      <= 1'b1;
      q.cdone     <= 1'b1;
      q.ready     <= 1'b1;
      q.irq_st    <= IRQ_RST;
      q.irq_msk   <= IRQ_RST;
    end
    else
    begin
      q <= s;
    end
  end

  assign wb_dat_o                = q.dat;
  assign wb_ack_o                = q.ack;
  assign irq_o                   = q.irq;
  assign hv_operation_enable_o   = q.ctrl[C_HV];
  assign done_o                  = q.done;
  assign integrity_check_done_o  = q.cdone;
  assign flash_ready_o           = q.ready;
  assign read_wait_states_o      = q.rws;
  assign addr_pipeline_setting_o = q.aps;

endmodule : flc_flash_seq

// [flc_seq_chk.sv]
module flc_seq_chk #(
  parameter int OP_CYCLES  = 1000,
  parameter int CHK_CYCLES = 1000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic hv_operation_enable_o,
  input wire logic done_o,
  input wire logic integrity_check_done_o,
  input wire logic flash_ready_o
);
  localparam int ABORT_N = 16000 / 8 + 4;
  localparam int RCV_N   = 16000 / 8 + 7;
  wire         hv = hv_operation_enable_o;
  logic [15:0] ab_q;
  logic [15:0] rl_q;
  logic        arm_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // spans too long for a repetition, so count them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ab_q  <= '0;
      arm_q <= 1'b0;
    end
    else if ($fell(hv) && !done_o)
    begin
      ab_q  <= 16'h0001;
      arm_q <= 1'b1;
    end
    else if (done_o)
      arm_q <= 1'b0;
    else
      ab_q  <= ab_q + 16'h0001;
    rl_q <= (rst_i || flash_ready_o) ? 16'h0000 : rl_q + 16'h0001;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_start_clear: assert property (
    $rose(hv) && $past(flash_ready_o) && $past(done_o) |-> !done_o)
    else $error("done not cleared at start");
  a_sleep_start: assert property (
    $rose(hv) && !$past(flash_ready_o) |-> done_o)
    else $error("start taken while not ready");
  a_abort_len: assert property (
    $rose(done_o) && arm_q |-> ab_q == ABORT_N)
    else $error("abort latency wrong");
  a_rcv_len: assert property ($rose(flash_ready_o) |-> rl_q >= RCV_N)
    else $error("recovery too short");
  a_idle_hold: assert property (!hv && done_o |=> done_o || hv)
    else $error("done dropped while idle");
  c_abort: cover property ($rose(done_o) && arm_q);
  c_wake: cover property ($rose(flash_ready_o));
  c_check: cover property ($fell(integrity_check_done_o));
endmodule : flc_seq_chk

bind flc_flash_seq flc_seq_chk #(.OP_CYCLES(OP_CYCLES),
  .CHK_CYCLES(CHK_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .hv_operation_enable_o(hv_operation_enable_o), .done_o(done_o),
  .integrity_check_done_o(integrity_check_done_o),
  .flash_ready_o(flash_ready_o));

// [flash_op_control_timing_tb.sv]
module flash_op_control_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flc_pkg::*;
  localparam int OPN = 20;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        wb_cyc_i = 0;
  logic        wb_stb_i = 0;
  logic        wb_we_i = 0;
  logic [7:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o, rd, d;
  logic        wb_ack_o, irq_o, hv, done_o, icd, rdy;
  logic [2:0]  rws;
  logic [1:0]  aps;
  logic [3:0]  sel_v = 4'hf;
  int          n_fail = 0, num_checks = 0, seed = 37, tmo = 0, n;
  logic [7:0]  st [4] = '{8'h10, 8'h10, 8'h90, 8'h90};
  logic [7:0]  sp [4] = '{8'h00, 8'h30, 8'h80, 8'hb0};
  logic [7:0]  su [2] = '{8'h70, 8'h30};
  logic [5:0]  tbl [4] = '{6'h00, 6'h12, 6'h13, 6'h14};

  flc_flash_seq #(.OP_CYCLES(OPN), .CHK_CYCLES(OPN)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .hv_operation_enable_o(hv),
    .done_o(done_o), .integrity_check_done_o(icd),
    .flash_ready_o(rdy), .read_wait_states_o(rws),
    .addr_pipeline_setting_o(aps));

  initial forever #4 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    tmo++;
    if (tmo == 30000)
    begin
      n_fail++;
      finish_test();
    end
  end

  function automatic int cyc(input real ns, input int plus);
    return int'($ceil(ns / 8.0)) + plus;
  endfunction : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // ends at the ack edge, so the write has just taken effect
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    wb_sel_i <= sel_v;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc

  // cycles from the write edge until the chosen flag is seen high
  task automatic lat(input int w);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while ((w == 0 ? done_o : w == 1 ? icd : rdy) !== 1'b1 && n < 5000);
    n = n - 1;
  endtask : lat

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(STAT_OFS, 32'h13);
    rdc(8'h14, 32'h0);
    wb(1'b1, 8'h14, 32'hffffffff);
    rdc(CTRL_OFS, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      d = (i < 4) ? 32'(tbl[i]) : $random(seed);
      wb(1'b1, RDCFG_OFS, d);
      rdc(RDCFG_OFS, d & 32'h37);
      check({26'h0, aps, 1'b0, rws}, d & 32'h37);
    end
    // low lane masked off, so the last setting must survive
    sel_v = 4'he;
    wb(1'b1, RDCFG_OFS, 32'h0);
    sel_v = 4'hf;
    rdc(RDCFG_OFS, d & 32'h37);
    $display("test config done");
    wb(1'b1, CTRL_OFS, 32'h1);
    #1 check(done_o, 1'b0);
    check(hv, 1'b1);
    lat(0);
    check(n, OPN);
    check(irq_o, 1'b0);
    wb(1'b1, IRQ_MSK_OFS, 32'h7);
    @(posedge clk_i);
    #1 check(irq_o, 1'b1);
    rdc(IRQ_ST_OFS, 32'h1);
    @(posedge clk_i);
    #1 check(irq_o, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b1, CTRL_OFS, 32'h3);
    lat(0);
    check(n, cyc(9400, 4));
    rdc(STAT_OFS, 32'h17);
    wb(1'b1, CTRL_OFS, 32'h1);
    #1 check(done_o, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0);
    lat(0);
    check(n, cyc(16000, 4));
    wb(1'b1, CTRL_OFS, 32'h9);
    wb(1'b1, CTRL_OFS, 32'hd);
    lat(0);
    check(n, cyc(16000, 4));
    wb(1'b1, CTRL_OFS, 32'h9);
    #1 check(done_o, 1'b0);
    lat(0);
    wb(1'b1, CTRL_OFS, 32'h0);
    $display("test program erase done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, CTRL_OFS, 32'(st[i]));
      #1 check(icd, 1'b0);
      wb(1'b1, CTRL_OFS, 32'(sp[i]));
      lat(1);
      check(n, i < 2 ? cyc(80, 15) : cyc(10360, 4));
      wb(1'b1, CTRL_OFS, 32'h0);
    end
    for (int j = 0; j < 2; j++)
    begin
      wb(1'b1, CTRL_OFS, 32'h10);
      wb(1'b1, CTRL_OFS, 32'(su[j]));
      lat(1);
      wb(1'b1, CTRL_OFS, 32'(su[j]) & 32'h30 ^ 32'h20 * j);
      #1 check(icd, 1'b0);
      lat(1);
      wb(1'b1, CTRL_OFS, 32'h0);
    end
    $display("test check done");
    wb(1'b0, IRQ_ST_OFS, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h100);
    wb(1'b1, CTRL_OFS, 32'h1);
    #1 check(done_o, 1'b1);
    lat(2);
    check(n, cyc(16000, 7));
    @(posedge clk_i);
    #1 check(irq_o, 1'b1);
    rdc(IRQ_ST_OFS, 32'h4);
    @(posedge clk_i);
    #1 check(irq_o, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0);
    $display("test low power done");
    finish_test();
  end
endmodule : flash_op_control_timing_tb
